// *** design/mac_defines.svh ***
// Constants shared by both ends of the multiply-accumulate register link.
// Assumes inclusion by bare name from files under design/.
`ifndef MAC_DEFINES_SVH
`define MAC_DEFINES_SVH

// Link widths
`define MAC_ADDR_BITS 4
`define MAC_DATA_BITS 8

// Register indices on the link
`define MAC_ADDR_MULT_X 4'h0
`define MAC_ADDR_MULT_Y 4'h1
`define MAC_ADDR_ACC_X 4'h2
`define MAC_ADDR_ACC_Y 4'h3
`define MAC_ADDR_PROD_LO 4'h4
`define MAC_ADDR_PROD_HI 4'h5
`define MAC_ADDR_ACC_B0 4'h6
`define MAC_ADDR_ACC_B1 4'h7
`define MAC_ADDR_ACC_B2 4'h8
`define MAC_ADDR_ACC_B3 4'h9
`define MAC_ADDR_CLR_A 4'ha
`define MAC_ADDR_CLR_B 4'hb

// Reset values
`define MAC_OPERAND_RST 8'h00
`define MAC_PRODUCT_RST 16'h0000
`define MAC_ACCUM_RST 32'h0000_0000
`define MAC_UNMAPPED_READ 8'h00

// Timing counts in link cycles
`define MAC_TRIGGER_GAP_CYCLES 1
`define MAC_READ_LATENCY 1

`endif

// *** design/mac_pkg.sv ***
// Types used by the host end of the multiply-accumulate register link.
// Assumes nothing beyond a SystemVerilog compiler.
package mac_pkg;

  // Host command kind
  typedef enum logic {
    CMD_WRITE = 1'b0,
    CMD_READ = 1'b1
  } cmd_op_t;

  // Host sequencer states, Gray along idle-bus-wait/gap
  typedef enum logic [1:0] {
    HOST_IDLE = 2'b00,
    HOST_BUS = 2'b01,
    HOST_WAIT = 2'b11,
    HOST_GAP = 2'b10
  } host_state_t;

  typedef logic [7:0] byte_t;

endpackage : mac_pkg

// *** design/mac_bus_if.sv ***
// Byte-wide register link between the processor end and the MAC unit.
// Assumes both ends run on the same clock; strobes are one-cycle pulses.
interface mac_bus_if;
  // Host to device
  logic wrEn;
  logic rdEn;
  logic [3:0] addr;
  logic [7:0] wrData;
  // Device to host
  logic [7:0] rdData;
  logic rdValid;

  modport device (
    input wrEn,
    input rdEn,
    input addr,
    input wrData,
    output rdData,
    output rdValid
  );

  modport host (
    output wrEn,
    output rdEn,
    output addr,
    output wrData,
    input rdData,
    input rdValid
  );
endinterface : mac_bus_if

// *** design/mac_unit.sv ***
// Signed multiply and multiply-accumulate unit, device end of the link.
// Assumes the host strobes one register access per cycle on core_clk.
//
// Operation
// - multiply-only operand write updates product, not accumulator
// - accumulate-trigger operand write adds product into accumulator
// - either X register loads the shared X operand
// - either Y register loads the shared Y operand
// - either clear register zeroes all accumulator bytes
// - operands are 8-bit signed two's complement
// - product is 16-bit signed, low and high byte
// - accumulator is 32-bit signed, four bytes, LSB first
// - product and low accumulator bytes valid next cycle
// - upper accumulator bytes valid one cycle later
// - host spaces accumulate triggers by one cycle
// - multiply writes and product reads run back to back
// - host loads first operand via multiply-only register
`include "mac_defines.svh"

module mac_unit #(
  parameter int ADDR_W = `MAC_ADDR_BITS,
  parameter int DATA_W = `MAC_DATA_BITS
) (
  // Clock and reset
  input logic core_clk,
  input logic resetn,
  // Register link
  mac_bus_if.device bus,
  // User-side observation of results
  output logic [15:0] productOut,
  output logic [31:0] accumOut,
  output logic accumHiPending
);

  // The decoder and byte lanes are built for exactly this shape, so any
  // other width is refused while the design is elaborated
  if (ADDR_W != `MAC_ADDR_BITS ||
      DATA_W != `MAC_DATA_BITS) begin : g_bad_shape
    $error("mac_unit: link must be 4 address and 8 data bits");
  end

  // Number of readable result bytes: two product, four accumulator
  localparam int RESULT_LANES = 6;

  // Architectural state. The accumulator is kept as two 16-bit halves;
  // the upper half follows a cycle late from the held carry and sign, so
  // software must not read its bytes straight after a trigger.
  logic [7:0] xOp_r;
  logic [7:0] yOp_r;
  logic [15:0] product_r;
  logic [15:0] accLo_r;
  logic [15:0] accHi_r;
  logic hiPending_r;
  logic hiCarry_r;
  logic hiSign_r;
  logic [7:0] rdData_r;
  logic rdValid_r;

  // Write decode. Result and unmapped indices decode to nothing, so a
  // stray write there changes no state.
  wire wrMultX = bus.wrEn && (bus.addr == `MAC_ADDR_MULT_X);
  wire wrMultY = bus.wrEn && (bus.addr == `MAC_ADDR_MULT_Y);
  wire wrAccX = bus.wrEn && (bus.addr == `MAC_ADDR_ACC_X);
  wire wrAccY = bus.wrEn && (bus.addr == `MAC_ADDR_ACC_Y);
  wire wrClrA = bus.wrEn && (bus.addr == `MAC_ADDR_CLR_A);
  wire wrClrB = bus.wrEn && (bus.addr == `MAC_ADDR_CLR_B);
  wire loadX = wrMultX || wrAccX;
  wire loadY = wrMultY || wrAccY;
  wire multOnly = wrMultX || wrMultY;
  wire accTrigger = wrAccX || wrAccY;
  wire accClear = wrClrA || wrClrB;

  // Operands as seen by this write: the byte being written replaces its
  // side, so the product never lags the write that triggered it
  wire [7:0] xNow = loadX ? bus.wrData : xOp_r;
  wire [7:0] yNow = loadY ? bus.wrData : yOp_r;

  // Signed 8x8 multiply; the 16-bit result cannot overflow, even for
  // the most negative operand squared
  wire signed [15:0] productNow = $signed(xNow) * $signed(yNow);

  // Low half of the accumulate, with carry held for the upper half.
  // Splitting the 32-bit add keeps the adder short, at the price of the
  // upper bytes settling one cycle after the trigger.
  wire [16:0] loSum = {1'b0, accLo_r} + {1'b0, productNow};
  wire [15:0] hiAddend = {16{hiSign_r}};
  wire [15:0] hiSum = accHi_r + hiAddend + {15'h0000, hiCarry_r};

  // Operand registers; they reload the held value on cycles without a
  // write, so no separate load enable reaches the flops
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      xOp_r <= `MAC_OPERAND_RST;
      yOp_r <= `MAC_OPERAND_RST;
    end else begin
      xOp_r <= xNow;
      yOp_r <= yNow;
    end
  end

  // Product register, loaded only by multiply-only writes. Triggers leave
  // it alone, so a product read back later is never disturbed by an
  // accumulation that happened in between.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      product_r <= `MAC_PRODUCT_RST;
    end else if (multOnly) begin
      product_r <= productNow;
    end
  end

  // Low accumulator half, valid the cycle after the trigger. Clear is
  // tested first, though one index can never carry both.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      accLo_r <= 16'(`MAC_ACCUM_RST);
    end else if (accClear) begin
      accLo_r <= 16'h0000;
    end else if (accTrigger) begin
      accLo_r <= loSum[15:0];
    end
  end

  // Carry and sign handed to the upper half one cycle later. They are
  // captured every cycle but only used after a trigger.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hiPending_r <= 1'b0;
      hiCarry_r <= 1'b0;
      hiSign_r <= 1'b0;
    end else begin
      hiPending_r <= accTrigger && !accClear;
      hiCarry_r <= loSum[16];
      hiSign_r <= productNow[15];
    end
  end

  // Upper accumulator half. A clear drops any pending upper update so the
  // whole accumulator reads zero afterwards. A second trigger in the very
  // next cycle is safe: the held carry and sign are used before they are recaptured.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      accHi_r <= 16'h0000;
    end else if (accClear) begin
      accHi_r <= 16'h0000;
    end else if (hiPending_r) begin
      accHi_r <= hiSum;
    end
  end

  // Read decode for the operand indices; both X indices read the one
  // shared X operand and both Y indices the shared Y operand
  wire rdMultX = bus.addr == `MAC_ADDR_MULT_X;
  wire rdAccX = bus.addr == `MAC_ADDR_ACC_X;
  wire rdMultY = bus.addr == `MAC_ADDR_MULT_Y;
  wire rdAccY = bus.addr == `MAC_ADDR_ACC_Y;

  // Result bytes in index order: product low and high, then the four
  // accumulator bytes from least to most significant
  wire [8*RESULT_LANES-1:0] resultBytes = {accHi_r, accLo_r, product_r};
  wire [RESULT_LANES-1:0] resultHit;
  wire [7:0] resultChain [RESULT_LANES+1];
  assign resultChain[0] = 8'h00;

  // One lane per result byte, indices following on from the product low
  // byte. A lane adds its byte only while its own index is addressed, so
  // the chain of ORs replaces a priority mux that grows with each lane.
  for (genvar lane = 0; lane < RESULT_LANES; lane++) begin : g_result_lane
    assign resultHit[lane] = bus.addr == 4'(`MAC_ADDR_PROD_LO + lane);
    assign resultChain[lane+1] = resultChain[lane] |
      (resultHit[lane] ? resultBytes[8*lane +: 8] : 8'h00);
  end

  // At most one lane matches, so the end of the chain is the result byte
  wire [7:0] resultByte = resultChain[RESULT_LANES];
  wire anyResult = |resultHit;

  // Read selection; clear registers and unmapped indices read zero
  wire [7:0] rdMux =
    (rdMultX || rdAccX) ? xOp_r :
    (rdMultY || rdAccY) ? yOp_r :
    anyResult ? resultByte :
    `MAC_UNMAPPED_READ;

  // Read answer, one cycle after the strobe. Data is captured only on a
  // read, so it stands until the next read for a slow host to take.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdData_r <= `MAC_UNMAPPED_READ;
      rdValid_r <= 1'b0;
    end else begin
      rdValid_r <= bus.rdEn;
      if (bus.rdEn) begin
        rdData_r <= rdMux;
      end
    end
  end

  // Link answer straight from its flops
  assign bus.rdData = rdData_r;
  assign bus.rdValid = rdValid_r;

  // User-side outputs come straight from the state flops; the upper
  // accumulator bytes may lag by one cycle while accumHiPending is high
  assign productOut = product_r;
  assign accumOut = {accHi_r, accLo_r};
  assign accumHiPending = hiPending_r;

endmodule : mac_unit

// *** design/mac_host.sv ***
// Processor end of the MAC register link: turns single commands into
// bus strokes and keeps the spacing the accumulator needs.
// Assumes one command at a time, handed over with valid and ready.
`include "mac_defines.svh"

module mac_host #(
  parameter int GAP_CYCLES = `MAC_TRIGGER_GAP_CYCLES
) (
  // Clock and reset
  input logic core_clk,
  input logic resetn,
  // Command port
  input logic cmdValid,
  input mac_pkg::cmd_op_t cmdOp,
  input logic [3:0] cmdAddr,
  input logic [7:0] cmdData,
  output logic cmdReady,
  // Read answer
  output logic respValid,
  output logic [7:0] respData,
  // Register link
  mac_bus_if.host bus
);

  // Refused while elaborating: the gap state is a single cycle
  if (GAP_CYCLES != 1) begin : g_bad_gap
    $error("mac_host: the gap sequencer inserts exactly one cycle");
  end

  mac_pkg::host_state_t state_r;
  mac_pkg::host_state_t state_nxt;
  logic cmdReady_r;
  logic respValid_r;
  logic [7:0] respData_r;
  logic wrEn_r;
  logic rdEn_r;
  logic [3:0] addr_r;
  logic [7:0] wrData_r;

  // Command acceptance and kind of stroke just issued
  // Gated by the ready flop so nothing is taken in the cycle right after
  // reset, while ready still shows low
  wire take = cmdReady_r && cmdValid && (state_r == mac_pkg::HOST_IDLE);
  wire issuedTrigger = wrEn_r &&
    (addr_r == `MAC_ADDR_ACC_X || addr_r == `MAC_ADDR_ACC_Y);

  // Next state; an accumulate trigger is always followed by an idle
  // cycle, which covers both a following trigger and an upper-byte read
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      mac_pkg::HOST_IDLE: begin
        if (take) begin
          state_nxt = mac_pkg::HOST_BUS;
        end
      end
      mac_pkg::HOST_BUS: begin
        if (rdEn_r) begin
          state_nxt = mac_pkg::HOST_WAIT;
        end else if (issuedTrigger) begin
          state_nxt = mac_pkg::HOST_GAP;
        end else begin
          state_nxt = mac_pkg::HOST_IDLE;
        end
      end
      mac_pkg::HOST_WAIT: begin
        if (bus.rdValid) begin
          state_nxt = mac_pkg::HOST_IDLE;
        end
      end
      mac_pkg::HOST_GAP: begin
        state_nxt = mac_pkg::HOST_IDLE;
      end
    endcase
  end

  // Sequencer and bus strokes; strobes last exactly one cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= mac_pkg::HOST_IDLE;
      wrEn_r <= 1'b0;
      rdEn_r <= 1'b0;
      addr_r <= 4'h0;
      wrData_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      wrEn_r <= take && (cmdOp == mac_pkg::CMD_WRITE);
      rdEn_r <= take && (cmdOp == mac_pkg::CMD_READ);
      if (take) begin
        addr_r <= cmdAddr;
        wrData_r <= cmdData;
      end
    end
  end

  // Ready and read answer, registered
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cmdReady_r <= 1'b0;
      respValid_r <= 1'b0;
      respData_r <= 8'h00;
    end else begin
      cmdReady_r <= (state_nxt == mac_pkg::HOST_IDLE);
      respValid_r <= (state_r == mac_pkg::HOST_WAIT) && bus.rdValid;
      if ((state_r == mac_pkg::HOST_WAIT) && bus.rdValid) begin
        respData_r <= bus.rdData;
      end
    end
  end

  // Operand order is the caller's job: load the first operand through a
  // multiply-only index, the second through an accumulate trigger
  assign cmdReady = cmdReady_r;
  assign respValid = respValid_r;
  assign respData = respData_r;
  assign bus.wrEn = wrEn_r;
  assign bus.rdEn = rdEn_r;
  assign bus.addr = addr_r;
  assign bus.wrData = wrData_r;

endmodule : mac_host

// *** bench/mac_link_checker.sv ***
// Concurrent checks on the MAC register link and the unit's result ports.
// Assumes one clock domain and one access per cycle on the link.
module mac_link_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Link
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [3:0] addr,
  input wire logic [7:0] wrData,
  input wire logic [7:0] rdData,
  input wire logic rdValid,
  // Unit results
  input wire logic [15:0] productOut,
  input wire logic [31:0] accumOut,
  input wire logic accumHiPending
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] xOp_r, yOp_r, xOp_nxt, yOp_nxt;
  logic signed [15:0] prodNxt;
  logic [31:0] accRef_r, accRef_nxt;
  wire multWr = wrEn && (addr == 4'h0 || addr == 4'h1);
  wire trig = wrEn && (addr == 4'h2 || addr == 4'h3);
  wire clr = wrEn && (addr == 4'ha || addr == 4'hb);
  wire [7:0] prodHi = productOut[15:8];
  wire [7:0] accTop = accumOut[31:24];

  // Reference operands and accumulator; the written byte counts at once
  assign xOp_nxt = (wrEn && (addr == 4'h0 || addr == 4'h2)) ? wrData : xOp_r;
  assign yOp_nxt = (wrEn && (addr == 4'h1 || addr == 4'h3)) ? wrData : yOp_r;
  assign prodNxt = $signed(xOp_nxt) * $signed(yOp_nxt);
  assign accRef_nxt = clr ? 32'h0000_0000 :
    trig ? accRef_r + {{16{prodNxt[15]}}, prodNxt} : accRef_r;

  // Reference state
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      xOp_r <= 8'h00;
      yOp_r <= 8'h00;
      accRef_r <= 32'h0000_0000;
    end else begin
      xOp_r <= xOp_nxt;
      yOp_r <= yOp_nxt;
      accRef_r <= accRef_nxt;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // Lower half lands first, the whole word one cycle later
  sequence accLoNow;
    accumOut[15:0] == accRef_r[15:0];
  endsequence
  sequence accAllNow;
    accumOut == accRef_r;
  endsequence

  a_read_answer: assert property (rdEn |=> rdValid)
    else $error("read answer missing");
  a_answer_cause: assert property (rdValid |-> $past(rdEn))
    else $error("read answer without request");
  a_product_value: assert property (
    multWr |=> productOut == $past(prodNxt))
    else $error("product wrong after multiply write");
  a_mult_keeps_acc: assert property (
    multWr && !accumHiPending |=> $stable(accumOut))
    else $error("multiply write disturbed accumulator");
  a_acc_two_step: assert property (
    trig |=> accLoNow ##1 accAllNow)
    else $error("accumulator result wrong or late");
  a_hi_pending: assert property (
    trig |=> accumHiPending ##1 !accumHiPending)
    else $error("upper update flag wrong");
  a_clear_all: assert property (clr |=> accumOut == 32'h0000_0000)
    else $error("clear left accumulator nonzero");
  a_trigger_gap: assert property (trig |=> !trig)
    else $error("accumulate triggers back to back");
  a_prod_read: assert property (
    rdEn && addr == 4'h5 |=> rdData == $past(prodHi))
    else $error("product high byte read wrong");
  a_acc_read: assert property (
    rdEn && addr == 4'h9 |=> rdData == $past(accTop))
    else $error("accumulator top byte read wrong");
endmodule : mac_link_checker

// *** bench/signed_multiply_accumulate_unit_tb_top.sv ***
// Self-checking bench: host end and MAC unit joined by the link.
// Assumes the design package, interface and defines are on the path.
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  n_errors++; $display("mismatch %s exp %h got %h", nm, e, g); end end

module signed_multiply_accumulate_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, resetn, cmdValid, cmdReady, respValid, accumHiPending;
  mac_pkg::cmd_op_t cmdOp;
  logic [3:0] cmdAddr;
  logic [7:0] cmdData, respData, xM, yM, v;
  logic [15:0] productOut, p;
  logic [31:0] accumOut, accM;
  logic [7:0] cx [3] = '{8'h80, 8'h7f, 8'hff};
  logic [7:0] cy [3] = '{8'h80, 8'h80, 8'h01};
  int n_errors = 0;
  int num_checks = 0;

  mac_bus_if bus ();
  mac_host u_mac_host (.core_clk(core_clk), .resetn(resetn),
    .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdAddr(cmdAddr),
    .cmdData(cmdData), .cmdReady(cmdReady), .respValid(respValid),
    .respData(respData), .bus(bus));
  mac_unit u_mac_unit (.core_clk(core_clk), .resetn(resetn), .bus(bus),
    .productOut(productOut), .accumOut(accumOut),
    .accumHiPending(accumHiPending));
  mac_link_checker u_mac_link_checker (.core_clk(core_clk),
    .resetn(resetn), .wrEn(bus.wrEn), .rdEn(bus.rdEn), .addr(bus.addr),
    .wrData(bus.wrData), .rdData(bus.rdData), .rdValid(bus.rdValid),
    .productOut(productOut), .accumOut(accumOut),
    .accumHiPending(accumHiPending));

  // 10 MHz clock
  always #50 core_clk = ~core_clk;

  // Expected product, sign handled by the $signed casts on both operands
  function automatic logic [15:0] prod(input logic [7:0] a, b);
    logic signed [15:0] r;
    r = $signed(a) * $signed(b);
    return r;
  endfunction : prod

  // One command; valid drops at the taking edge so it is never taken twice
  task automatic cmd(input mac_pkg::cmd_op_t op, input logic [3:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    cmdValid <= 1'b1;
    cmdOp <= op;
    cmdAddr <= a;
    cmdData <= d;
    @(negedge core_clk);
    while (cmdReady !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    if (n == 20) n_errors++;
    @(posedge core_clk);
    cmdValid <= 1'b0;
  endtask : cmd

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    cmd(mac_pkg::CMD_WRITE, a, d);
  endtask : wr

  // Read one index and compare the answer
  task automatic chk_rd(input logic [3:0] a, input logic [7:0] e,
                        input string nm);
    int n;
    n = 0;
    cmd(mac_pkg::CMD_READ, a, 8'h00);
    while (respValid !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    if (n == 20) n_errors++;
    `CHK(nm, e, respData)
  endtask : chk_rd

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  // Watchdog, well beyond the fewer than a thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    summarize();
  end

  // Main sequence
  initial begin
    core_clk = 1'b0;
    resetn = 1'b0;
    cmdValid = 1'b0;
    cmdOp = mac_pkg::CMD_WRITE;
    cmdAddr = 4'h0;
    cmdData = 8'h00;
    accM = 32'h0000_0000;
    void'($urandom(32'hc87cb1f6));
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    // Results and unmapped indices read zero out of reset
    for (int a = 4; a < 16; a++) chk_rd(4'(a), 8'h00, "idle");
    // Multiply only, extreme signed operands first
    for (int i = 0; i < 24; i++) begin
      xM = (i < 3) ? cx[i] : 8'($urandom);
      yM = (i < 3) ? cy[i] : 8'($urandom);
      wr(4'h0, xM);
      wr(4'h1, yM);
      p = prod(xM, yM);
      chk_rd(4'h4, p[7:0], "prodLo");
      chk_rd(4'h5, p[15:8], "prodHi");
      `CHK("productOut", p, productOut)
      `CHK("accumOut", accM, accumOut)
    end
    // Accumulate through both trigger registers
    wr(4'ha, 8'($urandom));
    for (int i = 0; i < 16; i++) begin
      xM = (i < 3) ? cy[i] : 8'($urandom);
      yM = (i < 3) ? cx[i] : 8'($urandom);
      if (i[0]) begin
        wr(4'h1, yM);
        wr(4'h2, xM);
      end else begin
        wr(4'h0, xM);
        wr(4'h3, yM);
      end
      p = prod(xM, yM);
      accM = accM + {{16{p[15]}}, p};
      chk_rd(4'h6, accM[7:0], "acc0");
      chk_rd(4'h7, accM[15:8], "acc1");
      chk_rd(4'h8, accM[23:16], "acc2");
      chk_rd(4'h9, accM[31:24], "acc3");
      // The trigger's operand must feed the next plain multiply
      v = 8'($urandom);
      if (i[0]) yM = v;
      else xM = v;
      wr(i[0] ? 4'h1 : 4'h0, v);
      p = prod(xM, yM);
      chk_rd(4'h4, p[7:0], "sharedLo");
      chk_rd(4'h5, p[15:8], "sharedHi");
      `CHK("keepAcc", accM, accumOut)
    end
    // Clear through the second clear index
    wr(4'hb, 8'($urandom));
    repeat (2) @(negedge core_clk);
    `CHK("cleared", 32'h0000_0000, accumOut)
    chk_rd(4'h9, 8'h00, "clearTop");
    // Accumulate once more, then clear through the first clear index
    xM = 8'($urandom) | 8'h01;
    yM = 8'($urandom) | 8'h01;
    wr(4'h0, xM);
    wr(4'h3, yM);
    p = prod(xM, yM);
    chk_rd(4'h6, p[7:0], "reAcc0");
    wr(4'ha, 8'($urandom));
    repeat (2) @(negedge core_clk);
    `CHK("clearA", 32'h0000_0000, accumOut)
    summarize();
  end
endmodule : signed_multiply_accumulate_unit_tb_top
